// ---- logic/nand_host_consts.svh ----
// Command codes, address layout and bus timing counts for the flash host controller
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH
// Command codes
`define CMD_MAIN_LO 8'h00
`define CMD_MAIN_HI 8'h01
`define CMD_SPARE 8'h50
`define CMD_IDENT 8'h90
`define CMD_RESET 8'hff
`define CMD_PROG 8'h80
`define CMD_PROG_GO 8'h10
`define CMD_ERASE 8'h60
`define CMD_ERASE_GO 8'hd0
`define CMD_STATUS 8'h70
// Page geometry
`define COL_LAST 10'h20f
`define COL_SPARE 10'h200
// Clock period, strobe times and busy settle time
`define CLK_NS 20
`define T_STROBE_LOW_NS 25
`define T_STROBE_HIGH_NS 15
`define T_BUSY_SETTLE_NS 100
// Least times round up to whole cycles
`define STROBE_LOW_CYC ((`T_STROBE_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_HIGH_CYC ((`T_STROBE_HIGH_NS + `CLK_NS - 1) / `CLK_NS)
`define BUSY_SETTLE_CYC ((`T_BUSY_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- logic/nand_host_pkg.sv ----
// Types shared by the flash host controller and its bus cycle engine
`default_nettype none
package nand_host_pkg;
  // Operations the user may request
  typedef enum logic [2:0] {
    OP_MAIN = 3'h0, OP_SPARE = 3'h1, OP_IDENT = 3'h2, OP_RESET = 3'h3,
    OP_PROG = 3'h4, OP_ERASE = 3'h5, OP_STATUS = 3'h6
  } op_e;
  // One user request
  typedef struct packed {
    op_e op;
    logic [25:0] addr;
    logic [9:0] len;
  } host_cmd_s;
  // Bus cycle engine phases
  typedef enum logic [3:0] {
    CY_IDLE = 4'h1, CY_SET = 4'h2, CY_LOW = 4'h4, CY_HIGH = 4'h8
  } cyc_e;
  // Sequencer states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_CMD = 8'h02, ST_ADDR = 8'h04, ST_WDATA = 8'h08,
    ST_CONF = 8'h10, ST_WAIT = 8'h20, ST_RDATA = 8'h40, ST_END = 8'h80
  } host_st_e;
endpackage
`default_nettype wire

// ---- logic/nand_bus_cycle.sv ----
// One write or read strobe cycle on the flash bus
`include "nand_host_consts.svh"
`default_nettype none
module nand_bus_cycle import nand_host_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Request
  input wire logic start,
  input wire logic is_read,
  input wire logic [7:0] wr_byte,
  // Pins
  input wire logic [7:0] bus_in,
  output logic we_n,
  output logic read_strobe_n,
  output logic oe,
  output logic [7:0] bus_out,
  // Result
  output logic [7:0] rd_byte,
  output logic done
);
  cyc_e st_q, st_d; // Phase
  logic rd_q, rd_d; // Cycle is a read
  logic [1:0] cnt_q, cnt_d; // Phase time left
  logic [7:0] out_q, out_d; // Byte driven
  logic [7:0] cap_q, cap_d; // Byte sampled
  logic done_q, done_d; // End pulse

  // Next phase; the byte stays on the bus through the high phase for hold
  always_comb begin
    st_d = st_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    out_d = out_q;
    cap_d = cap_q;
    done_d = 1'b0;
    case (st_q)
      CY_IDLE: begin
        if (start) begin
          st_d = CY_SET;
          rd_d = is_read;
          out_d = wr_byte;
        end
      end
      CY_SET: begin
        // One setup cycle before the strobe falls
        st_d = CY_LOW;
        cnt_d = 2'(`STROBE_LOW_CYC - 1);
      end
      CY_LOW: begin
        if (cnt_q == 2'h0) begin
          st_d = CY_HIGH;
          cnt_d = 2'(`STROBE_HIGH_CYC - 1);
          // Sample at the end of the low time, past the access delay
          if (rd_q) begin
            cap_d = bus_in;
          end
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      CY_HIGH: begin
        if (cnt_q == 2'h0) begin
          st_d = CY_IDLE;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      default: st_d = CY_IDLE;
    endcase
  end

  // Phase registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= CY_IDLE;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      out_q <= 8'h00;
      cap_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      cap_q <= cap_d;
      done_q <= done_d;
    end
  end

  // R24 strobes and drive enable, registered; reads never drive
  logic we_n_q, rs_n_q, oe_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      we_n_q <= 1'b1;
      rs_n_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      we_n_q <= !(st_d == CY_LOW && !rd_d);
      rs_n_q <= !(st_d == CY_LOW && rd_d);
      oe_q <= (st_d != CY_IDLE) && !rd_d;
    end
  end

  assign we_n = we_n_q;
  assign read_strobe_n = rs_n_q;
  assign oe = oe_q;
  assign bus_out = out_q;
  assign rd_byte = cap_q;
  assign done = done_q;
endmodule // nand_bus_cycle
`default_nettype wire

// ---- logic/nand_host.sv ----
// Host controller that drives a small-page flash over its multiplexed bus
// What this block and the device do
// R1 - Command byte latched with command strobe only
// R2 - Write-protect high during program and erase
// R3 - Four address bytes (three for erase, one for identification) with address strobe only
// R4 - Address bytes map A0-7, A9-16, A17-24, A25
// R5 - A8 chosen by code 00h or 01h
// R6 - Out-of-range address bits are ignored
// R7 - Data bytes loaded with both latches low
// R8 - Data read with read strobe, latches low
// R9 - Each read strobe advances the column
// R10 - Output path carries status and identification
// R11 - Protect low blocks every modify operation
// R12 - Chip select high deselects and idles
// R13 - Only reset and status accepted while busy
// R14 - Device decodes the listed command codes
// R15 - Copy-back confirm code may be omitted
// R16 - Power-up defaults to first-half read
// R17 - Page change loads page, busy meanwhile
// R18 - After last column next page reloads
// R19 - Row read ends on chip select high
// R20 - Chip select high in reload keeps reading
// R21 - Spare read points at bytes 512-527
// R22 - Spare pointer stays until main read
// R23 - Wait for ready before reading data
// R24 - Device floats bus when not reading
`include "nand_host_consts.svh"
`default_nettype none
module nand_host import nand_host_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // User request port
  input wire logic cmd_valid,
  input wire host_cmd_s cmd,
  output logic cmd_ready,
  output logic op_done,
  // Program data in
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  // Read data out
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Flash control pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic read_strobe_n,
  output logic wp_n,
  // Flash bus and ready line
  input wire logic [7:0] bus_lines_i,
  output logic [7:0] bus_lines_o,
  output logic bus_lines_oe,
  input wire logic ready_busy_i
);
  host_st_e st_q, st_d; // Sequencer state
  op_e op_q, op_d; // Operation in progress
  logic [25:0] addr_q, addr_d; // Flash address
  logic [9:0] len_q, len_d; // Bytes left
  logic [9:0] col_q, col_d; // Column pointer
  logic [1:0] idx_q, idx_d; // Address cycle index
  logic [1:0] last_q, last_d; // Final address cycle
  logic [2:0] wb_q, wb_d; // Settle count before sampling ready
  logic fly_q, fly_d; // Bus cycle in flight
  logic ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, wp_n_q, wp_n_d;
  logic rdy_q, rdy_d, done_q, done_d, wrr_q, wrr_d, rdv_q, rdv_d;
  logic [7:0] rdd_q, rdd_d;
  logic go, go_rd; // Cycle start request
  logic [7:0] go_byte; // Byte for a write cycle
  logic cyc_done; // Cycle finished
  logic [7:0] cyc_byte; // Byte read back
  logic [7:0] addr_byte; // Address byte for this cycle

  // Address byte selection; A8 never goes out on the bus
  always_comb begin
    // R4 R6 address byte map, top bits low
    case (idx_q)
      2'h0: addr_byte = addr_q[7:0];
      2'h1: addr_byte = addr_q[16:9];
      2'h2: addr_byte = addr_q[24:17];
      default: addr_byte = {7'h00, addr_q[25]};
    endcase
  end

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    len_d = len_q;
    col_d = col_q;
    idx_d = idx_q;
    last_d = last_q;
    wb_d = wb_q;
    ce_n_d = ce_n_q;
    cle_d = cle_q;
    ale_d = ale_q;
    wp_n_d = wp_n_q;
    rdy_d = 1'b0;
    done_d = 1'b0;
    wrr_d = 1'b0;
    rdv_d = 1'b0;
    rdd_d = rdd_q;
    go = 1'b0;
    go_rd = 1'b0;
    go_byte = 8'h00;
    case (st_q)
      ST_IDLE: begin
        rdy_d = 1'b1;
        if (cmd_valid && rdy_q) begin
          rdy_d = 1'b0;
          op_d = cmd.op;
          addr_d = (cmd.op == OP_IDENT) ? 26'h0 : cmd.addr;
          len_d = (cmd.op == OP_IDENT) ? 10'h002 : (cmd.op == OP_STATUS) ? 10'h001 : cmd.len;
          // R21 spare pointer start
          col_d = (cmd.op == OP_SPARE) ? (`COL_SPARE | {6'h00, cmd.addr[3:0]}) : {1'b0, cmd.addr[8:0]};
          idx_d = (cmd.op == OP_ERASE) ? 2'h1 : 2'h0;
          last_d = (cmd.op == OP_IDENT) ? 2'h0 : 2'h3;
          ce_n_d = 1'b0;
          // R2 protect released for modify
          wp_n_d = (cmd.op == OP_PROG) || (cmd.op == OP_ERASE);
          cle_d = 1'b1;
          st_d = ST_CMD;
        end
      end
      ST_CMD: begin
        // R13 hold off while busy
        if (!fly_q && (ready_busy_i || op_q == OP_RESET || op_q == OP_STATUS)) begin
          go = 1'b1;
        end
        // R5 R14 R15 R16 code per op, no copy-back
        case (op_q)
          OP_MAIN: go_byte = addr_q[8] ? `CMD_MAIN_HI : `CMD_MAIN_LO;
          OP_SPARE: go_byte = `CMD_SPARE;
          OP_IDENT: go_byte = `CMD_IDENT;
          OP_RESET: go_byte = `CMD_RESET;
          OP_PROG: go_byte = `CMD_PROG;
          OP_ERASE: go_byte = `CMD_ERASE;
          default: go_byte = `CMD_STATUS;
        endcase
        if (cyc_done) begin
          cle_d = 1'b0;
          wb_d = 3'(`BUSY_SETTLE_CYC);
          if (op_q == OP_RESET) begin
            st_d = ST_WAIT;
          end else if (op_q == OP_STATUS) begin
            st_d = ST_RDATA;
          end else begin
            ale_d = 1'b1;
            st_d = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        // R3 R17 address cycles, then load wait for main and spare reads
        go = !fly_q;
        go_byte = addr_byte;
        if (cyc_done) begin
          idx_d = idx_q + 2'h1;
          if (idx_q == last_q) begin
            ale_d = 1'b0;
            wb_d = 3'(`BUSY_SETTLE_CYC);
            case (op_q)
              OP_IDENT: st_d = ST_RDATA;
              OP_PROG: st_d = (len_q == 10'h000) ? ST_CONF : ST_WDATA;
              OP_ERASE: st_d = ST_CONF;
              default: st_d = ST_WAIT;
            endcase
            cle_d = (op_q == OP_ERASE) || (op_q == OP_PROG && len_q == 10'h000);
          end
        end
      end
      ST_WDATA: begin
        // R7 serial data load
        if (!fly_q && wr_valid && len_q != 10'h000) begin
          go = 1'b1;
          wrr_d = 1'b1;
          len_d = len_q - 10'h001;
        end
        go_byte = wr_data;
        if (cyc_done && len_q == 10'h000) begin
          cle_d = 1'b1;
          st_d = ST_CONF;
        end
      end
      ST_CONF: begin
        go = !fly_q;
        go_byte = (op_q == OP_PROG) ? `CMD_PROG_GO : `CMD_ERASE_GO;
        if (cyc_done) begin
          cle_d = 1'b0;
          wb_d = 3'(`BUSY_SETTLE_CYC);
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // R23 wait for ready line
        if (wb_q != 3'h0) begin
          wb_d = wb_q - 3'h1;
        end else if (ready_busy_i) begin
          st_d = ((op_q == OP_MAIN || op_q == OP_SPARE) && len_q != 10'h000) ? ST_RDATA : ST_END;
        end
      end
      ST_RDATA: begin
        // R8 R10 serial data out
        go = !fly_q;
        go_rd = 1'b1;
        if (cyc_done) begin
          rdv_d = 1'b1;
          rdd_d = cyc_byte;
          len_d = len_q - 10'h001;
          col_d = col_q + 10'h001;
          if (len_q == 10'h001) begin
            st_d = ST_END;
          end
          // R9 R18 R22 column step, page wrap
          if ((op_q == OP_MAIN || op_q == OP_SPARE) && col_q == `COL_LAST) begin
            col_d = (op_q == OP_SPARE) ? `COL_SPARE : 10'h000;
            wb_d = 3'(`BUSY_SETTLE_CYC);
            st_d = ST_WAIT;
          end
        end
      end
      ST_END: begin
        // R11 R12 R19 R20 deselect without checking ready; only a status read can end while busy
        ce_n_d = 1'b1;
        wp_n_d = 1'b0;
        done_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Sequencer registers; protect is held low whenever no modify runs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      op_q <= OP_MAIN;
      addr_q <= 26'h0;
      len_q <= 10'h000;
      col_q <= 10'h000;
      idx_q <= 2'h0;
      last_q <= 2'h0;
      wb_q <= 3'h0;
      ce_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      wp_n_q <= 1'b0;
      rdy_q <= 1'b0;
      done_q <= 1'b0;
      wrr_q <= 1'b0;
      rdv_q <= 1'b0;
      rdd_q <= 8'h00;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      len_q <= len_d;
      col_q <= col_d;
      idx_q <= idx_d;
      last_q <= last_d;
      wb_q <= wb_d;
      ce_n_q <= ce_n_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      wp_n_q <= wp_n_d;
      rdy_q <= rdy_d;
      done_q <= done_d;
      wrr_q <= wrr_d;
      rdv_q <= rdv_d;
      rdd_q <= rdd_d;
    end
  end

  // In-flight flag for the strobe engine
  always_comb begin
    fly_d = go ? 1'b1 : (cyc_done ? 1'b0 : fly_q);
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fly_q <= 1'b0;
    end else begin
      fly_q <= fly_d;
    end
  end

  // Strobe engine
  nand_bus_cycle u_cycle (
    .clock(clock),
    .rst(rst),
    .start(go),
    .is_read(go_rd),
    .wr_byte(go_byte),
    .bus_in(bus_lines_i),
    .we_n(we_n),
    .read_strobe_n(read_strobe_n),
    .oe(bus_lines_oe),
    .bus_out(bus_lines_o),
    .rd_byte(cyc_byte),
    .done(cyc_done)
  );

  assign ce_n = ce_n_q;
  assign cle = cle_q;
  assign ale = ale_q;
  assign wp_n = wp_n_q;
  assign cmd_ready = rdy_q;
  assign op_done = done_q;
  assign wr_ready = wrr_q;
  assign rd_valid = rdv_q;
  assign rd_data = rdd_q;

  // Pin protocol checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  cmd_latch_pins_a: assert property ($rose(we_n) && cle |-> !ce_n && !ale && read_strobe_n) // R1
    else $error("command latched with wrong pins");
  wp_modify_a: assert property ($rose(we_n) && cle && (bus_lines_o == `CMD_PROG || bus_lines_o == `CMD_ERASE
    || bus_lines_o == `CMD_PROG_GO || bus_lines_o == `CMD_ERASE_GO) |-> wp_n) // R2
    else $error("modify command with protect low");
  addr_latch_pins_a: assert property ($rose(we_n) && ale |-> !ce_n && !cle && read_strobe_n) // R3
    else $error("address latched with wrong pins");
  addr_top_byte_a: assert property ($rose(we_n) && ale && $past(idx_q) == 2'h3 |-> bus_lines_o[7:1] == 7'h00) // R4
    else $error("fourth address byte high bits set");
  data_in_pins_a: assert property ($rose(we_n) && !cle && !ale |-> !ce_n && read_strobe_n && wp_n) // R7
    else $error("data byte loaded with wrong pins");
  data_out_pins_a: assert property ($fell(read_strobe_n) |-> !ce_n && we_n && !cle && !ale && !bus_lines_oe) // R8
    else $error("read strobe with wrong pins");
  end_ready_a: assert property ($rose(ce_n) |-> $past(ready_busy_i) && we_n && read_strobe_n) // R19
    else $error("deselect during busy");
  read_ready_a: assert property (st_q == ST_WAIT && !ready_busy_i |=> st_q == ST_WAIT) // R23
    else $error("left wait while busy");
  strobe_len_a: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*2] ##1 read_strobe_n) // R8
    else $error("read strobe low time wrong");
  cmd_issue_c: cover property ($rose(we_n) && cle);
  page_wrap_c: cover property (st_q == ST_RDATA ##1 st_q == ST_WAIT);
  prog_done_c: cover property (op_q == OP_PROG && op_done);
endmodule // nand_host
`default_nettype wire

// ---- dv/flash_model.sv ----
// Behavioural small-page flash that answers the host controller on its pins
`default_nettype none
module flash_model #(
  parameter logic [7:0] STAT_V = 8'hc0, // Status byte returned
  parameter logic [7:0] ID_A = 8'h5a, // Arbitrary value
  parameter logic [7:0] ID_B = 8'h3c, // Arbitrary value
  parameter int BUSY = 8 // Busy cycles after load or start
) (
  // Clock that samples the pins and counts down busy
  input wire logic clock,
  // Control pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  // Bus and ready line
  input wire logic [7:0] din,
  output logic [7:0] dq_o,
  output logic rb,
  // Logs for the bench
  output logic [15:0] c_log = 16'h0,
  output logic [31:0] a_log = 32'h0,
  output logic [9:0] w_cnt = 10'h0,
  output logic [7:0] w_sum = 8'h0,
  output logic [7:0] m_err = 8'h0
);
  logic we_q = 1'b1; // Last write strobe
  logic rs_q = 1'b1; // Last read strobe
  logic a8 = 1'b0; // Half chosen by read code
  logic idx = 1'b0; // Identification byte index
  logic [2:0] mode = 3'h0; // 0 main, 1 spare, 2 id, 3 status, 4 program, 5 erase
  logic [1:0] na = 2'h0; // Address bytes seen
  logic [16:0] page = 17'h0; // Loaded page
  logic [9:0] col = 10'h0; // Column pointer
  logic [7:0] dout = 8'h0; // Byte on the bus
  int bcnt = 0; // Busy countdown
  // Released bus shows the inverse of the last byte, so a stale sample fails
  // the inverse stands in for a floating bus
  assign dq_o = (!ce_n && !read_strobe_n) ? dout : ~dout;
  assign rb = (bcnt == 0);
  // Strobes last two cycles, so sampling on the clock misses no edge
  always @(posedge clock) begin
    we_q <= we_n;
    rs_q <= read_strobe_n;
    if (bcnt != 0)
      bcnt <= bcnt - 1;
    if (!ce_n && we_n && !we_q) begin
      if (!read_strobe_n || (cle && ale))
        m_err <= m_err + 8'h1;
      else if (cle) begin
        c_log <= {c_log[7:0], din};
        na <= 2'h0;
        // only reset and status while busy
        if (bcnt != 0 && din != 8'hff && din != 8'h70)
          m_err <= m_err + 8'h1;
        case (din)
          8'h00, 8'h01: begin
            mode <= 3'h0;
            a8 <= din[0];
          end
          8'h50: mode <= 3'h1;
          8'h90: begin
            mode <= 3'h2;
            idx <= 1'b0;
          end
          8'h70: mode <= 3'h3;
          8'h80: begin
            mode <= 3'h4;
            w_cnt <= 10'h0;
            w_sum <= 8'h0;
          end
          8'h60: mode <= 3'h5;
          8'h10, 8'hd0: begin
            if (wp_n)
              bcnt <= BUSY;
            else
              m_err <= m_err + 8'h1;
          end
          8'hff: begin
            mode <= 3'h0;
            a8 <= 1'b0;
            bcnt <= BUSY;
          end
          default: m_err <= m_err + 8'h1;
        endcase
      end else if (ale) begin
        na <= na + 2'h1;
        a_log <= (na == 2'h0) ? {24'h0, din} : {a_log[23:0], din};
        if (na == 2'h3 && mode < 3'h2) begin
          page <= {din[0], a_log[7:0], a_log[15:8]};
          col <= mode[0] ? {6'h20, a_log[19:16]} : {1'b0, a8, a_log[23:16]};
          bcnt <= BUSY;
        end
      end else if (mode == 3'h4 && wp_n) begin
        w_cnt <= w_cnt + 10'h1;
        w_sum <= w_sum + din;
      end else
        m_err <= m_err + 8'h1;
    end
    if (!ce_n && !read_strobe_n && rs_q && we_n && !cle && !ale) begin
      if (mode == 3'h3)
        dout <= STAT_V;
      else if (mode == 3'h2) begin
        dout <= idx ? ID_B : ID_A;
        idx <= 1'b1;
      end else begin
        if (bcnt != 0)
          m_err <= m_err + 8'h1;
        dout <= page[7:0] ^ col[7:0] ^ {6'h0, col[9:8]};
        col <= (col == 10'h20f) ? {mode[0], 9'h0} : col + 10'h1;
        if (col == 10'h20f) begin
          page <= page + 17'h1;
          bcnt <= BUSY;
        end
      end
    end
  end
endmodule // flash_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the flash host controller against the flash model
`default_nettype none
module tb_top import nand_host_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] STAT_V = 8'hc0; // Status byte of the model
  localparam logic [7:0] ID_A = 8'h5a; // Arbitrary value
  localparam logic [7:0] ID_B = 8'h3c; // Arbitrary value
  // Design inputs
  logic clock, rst, cmd_valid, wr_valid;
  host_cmd_s cmd;
  logic [7:0] wr_data;
  // Design outputs and model pins
  logic cmd_ready, op_done, wr_ready, rd_valid, ce_n, cle, ale, we_n, read_strobe_n, wp_n, bus_oe, rb;
  logic [7:0] rd_data, bus_o, dq, w_sum, m_err;
  logic [15:0] c_log;
  logic [31:0] a_log;
  logic [9:0] w_cnt;
  // Bench state
  int n_mismatch, cmp_count, j;
  logic [31:0] rnd;
  logic [25:0] ad;
  nand_host dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .op_done(op_done), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
    .bus_lines_i(bus_oe ? bus_o : dq), .bus_lines_o(bus_o), .bus_lines_oe(bus_oe), .ready_busy_i(rb));
  flash_model #(.STAT_V(STAT_V), .ID_A(ID_A), .ID_B(ID_B), .BUSY(8)) model (.clock(clock), .ce_n(ce_n),
    .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n), .din(bus_o), .dq_o(dq), .rb(rb),
    .c_log(c_log), .a_log(a_log), .w_cnt(w_cnt), .w_sum(w_sum), .m_err(m_err));
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Repeatable random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Array contents as the model fills them
  function automatic logic [7:0] dat(input logic [16:0] p, input logic [9:0] c);
    return p[7:0] ^ c[7:0] ^ {6'h0, c[9:8]};
  endfunction
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One operation: hand over, feed data, check bytes, then check what the model saw
  task automatic run(input op_e op, input logic [25:0] a, input logic [9:0] n);
    int i;
    int k;
    int nr;
    logic [16:0] pg;
    logic [9:0] col;
    logic [7:0] sum;
    pg = a[25:9];
    col = (op == OP_SPARE) ? {6'h20, a[3:0]} : {1'b0, a[8:0]};
    sum = 8'h0;
    nr = 0;
    cmd = '{op: op, addr: a, len: n};
    cmd_valid = 1'b1;
    wr_valid = (op == OP_PROG);
    rnd = lfsr(rnd);
    wr_data = rnd[7:0];
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++)
      @(negedge clock);
    if (i == 50) begin
      n_mismatch++;
      close_out();
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    for (k = 0; k < 20000 && op_done !== 1'b1; k++) begin
      if (rd_valid === 1'b1) begin
        if (op == OP_STATUS)
          check(32'(rd_data), 32'(STAT_V));
        else if (op == OP_IDENT)
          check(32'(rd_data), 32'(nr == 0 ? ID_A : ID_B));
        else begin
          check(32'(rd_data), 32'(dat(pg, col)));
          pg = (col == 10'h20f) ? pg + 17'h1 : pg;
          col = (col == 10'h20f) ? ((op == OP_SPARE) ? 10'h200 : 10'h0) : col + 10'h1;
        end
        nr++;
      end
      if (wr_ready === 1'b1) begin
        sum = sum + wr_data;
        rnd = lfsr(rnd);
        wr_data = rnd[7:0];
      end
      @(negedge clock);
    end
    wr_valid = 1'b0;
    if (k == 20000) begin
      n_mismatch++;
      close_out();
    end
    check(32'(ce_n), 32'h1);
    case (op)
      OP_MAIN, OP_SPARE: begin
        check(32'(nr), 32'(n));
        check(32'(c_log[7:0]), (op == OP_SPARE) ? 32'h50 : 32'(a[8]));
        check(a_log, {a[7:0], a[16:9], a[24:17], 7'h0, a[25]});
      end
      OP_PROG: begin
        check(32'(w_cnt), 32'(n));
        check(32'(w_sum), 32'(sum));
        check(32'(c_log), 32'h8010);
        check(a_log, {a[7:0], a[16:9], a[24:17], 7'h0, a[25]});
      end
      OP_ERASE: begin
        check(32'(c_log), 32'h60d0);
        check(a_log, {8'h0, a[16:9], a[24:17], 7'h0, a[25]});
      end
      OP_RESET: check(32'(c_log[7:0]), 32'hff);
      OP_STATUS: check(32'(nr), 32'h1);
      default: check(32'(nr), 32'h2);
    endcase
    @(negedge clock);
  endtask
  // Main sequence: corners first, then random operations
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    wr_valid = 1'b0;
    cmd = '0;
    wr_data = 8'h0;
    rnd = 32'hccc35103;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (20) @(negedge clock);
    check(32'(ce_n), 32'h1);
    check(32'(wp_n), 32'h0);
    check(32'(bus_oe), 32'h0);
    check(32'(cmd_ready), 32'h0);
    rst = 1'b0;
    @(negedge clock);
    @(negedge clock);
    run(OP_STATUS, 26'h0, 10'h1);
    run(OP_IDENT, 26'h0, 10'h2);
    run(OP_RESET, 26'h0, 10'h0);
    // Upper half, last page, crossing the page end
    run(OP_MAIN, {17'h1ffff, 9'h1fc}, 10'h18);
    run(OP_SPARE, {17'h00123, 9'h0e}, 10'h14);
    run(OP_PROG, 26'h0, 10'h0);
    // Program with data and an erase, whatever the random mix brings
    run(OP_PROG, 26'h1f0a5c3, 10'h3);
    run(OP_ERASE, 26'h2345678, 10'h0);
    for (j = 0; j < 14; j++) begin
      rnd = lfsr(rnd);
      ad = rnd[25:0];
      rnd = lfsr(rnd);
      run(op_e'(rnd[2:0] == 3'h7 ? 3'h0 : rnd[2:0]), ad, {6'h0, rnd[13:10]} + 10'h1);
    end
    check(32'(m_err), 32'h0);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
